/* File: src/tec_pkg.sv */
package tec_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [1:0] COUNT_VALUE_OFS = 2'h0;
    localparam logic [1:0] MODE_CONTROL_OFS = 2'h1;
    localparam logic [7:0] COUNT_VALUE_RST = 8'h00;
    localparam logic [7:0] MODE_CONTROL_RST = 8'h08;

    // ------------------------------------------------------------
    // mode control field positions
    // ------------------------------------------------------------
    localparam int MODE_HI_POS = 7;
    localparam int MODE_LO_POS = 6;
    localparam int SRC_POS = 5;
    localparam int RUN_POS = 4;
    localparam int EDGE_POS = 3;
    localparam int PSC_HI_POS = 2;
    localparam int PSC_LO_POS = 0;
    localparam int PSC_STAGES = 8;

    // ------------------------------------------------------------
    // count mode codes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;
    localparam logic [7:0] COUNT_FULL = 8'hff;

    // pulse measurement states
    typedef enum logic [2:0] {
        TEC_IDLE = 3'b001,
        TEC_ARMED = 3'b010,
        TEC_MEASURE = 3'b100
    } tec_pulse_state_t;

    // register bus request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tec_bus_req_t;

endpackage : tec_pkg

/* File: src/tec_timer.sv */
`timescale 1ns/100ps
// What this block does
// - mode field: 01 event count, 10 interval timer, 11 pulse width, 00 unused
// - tick source bit picks system clock when 0, sub clock when 1
// - prescale field divides tick clock by 1 up to 128 in powers of two
// - counter runs only while run bit is set; clearing it stops counting
// - timer mode increments on each falling edge of prescaled tick
// - passing FFH overflows: request raised, preload reloaded, counting goes on
// - event mode counts rising edges at polarity 0, falling at polarity 1
// - pulse mode: run bit only arms; counting waits for the starting edge
// - pulse mode counts from falling to rising (pol 0) or rising to falling
// - pulse end clears run bit, holds count, ignores edges until rearmed
// - in timer and event modes only software clears the run bit, bar a stop edge in the cycle after a write quits pulse mode mid-measure
// - counting continues while asleep; overflow gives request and wake-up
// - pulse mode start edge counts from the next timer tick; the stop edge ends the count at once
// - count reads and preload writes inhibit the counter clock that cycle
// - preload write while stopped loads counter; while running waits overflow
// - every overflow sets the request flag, enabled or not
module tec_timer (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // register port
    input wire tec_pkg::tec_bus_req_t bus_req,
    output logic [7:0] rdata,
    // clock sources and event pin
    input wire logic sub_clock,
    input wire logic event_input_pin,
    // events
    output logic overflow_irq,
    output logic wake_up
);

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0] timer_mode_control;
    logic [7:0] preload;
    logic [7:0] count_value_reg;
    logic [2:0] sub_sync;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [2:0] sync_fill;
    logic [tec_pkg::PSC_STAGES-1:0] psc_div;
    wire logic [tec_pkg::PSC_STAGES-1:0] psc_carry;
    logic tick_prev;
    tec_pkg::tec_pulse_state_t pstate;

    logic [1:0] count_mode_sel;
    logic tick_source_sel;
    logic count_run;
    logic edge_polarity;
    logic [2:0] prescale_sel;
    logic src_pulse;
    logic prescaler_input_clock;
    logic tick_fall;
    logic pin_rise;
    logic pin_fall;
    logic start_edge;
    logic stop_edge;
    logic inhibit;
    logic count_step;
    logic ovf;
    logic wr_ctl;
    logic wr_cnt;
    logic pulse_end;

    assign count_mode_sel = timer_mode_control[tec_pkg::MODE_HI_POS:tec_pkg::MODE_LO_POS];
    assign tick_source_sel = timer_mode_control[tec_pkg::SRC_POS];
    assign count_run = timer_mode_control[tec_pkg::RUN_POS];
    assign edge_polarity = timer_mode_control[tec_pkg::EDGE_POS];
    assign prescale_sel = timer_mode_control[tec_pkg::PSC_HI_POS:tec_pkg::PSC_LO_POS];

    // decode of a write strobe at one offset, used for both registers
    function automatic logic wr_hit(input tec_pkg::tec_bus_req_t r, input logic [1:0] ofs);
        wr_hit = r.wr && (r.addr == ofs);
    endfunction : wr_hit

    assign wr_ctl = wr_hit(bus_req, tec_pkg::MODE_CONTROL_OFS);
    assign wr_cnt = wr_hit(bus_req, tec_pkg::COUNT_VALUE_OFS);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // two-stage synchroniser; sync_fill marks when the flops hold real samples
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pin_sync <= 2'h0;
            pin_prev <= 1'b0;
            sub_sync <= 3'h0;
            sync_fill <= 3'h0;
        end else if (clk_en) begin
            pin_sync <= {pin_sync[0], event_input_pin};
            pin_prev <= pin_sync[1];
            sub_sync <= {sub_sync[1:0], sub_clock};
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    // edges wait for a full pipe, so a pin sitting high at reset is no false edge
    assign pin_rise = sync_fill[2] && pin_sync[1] && !pin_prev;
    assign pin_fall = sync_fill[2] && !pin_sync[1] && pin_prev;

    // ------------------------------------------------------------
    // tick source and prescaler
    // ------------------------------------------------------------
    // source choice: system clock gives a tick every cycle, sub clock on its rise
    assign src_pulse = tick_source_sel ? (sync_fill[2] && sub_sync[1] && !sub_sync[2]) : 1'b1;

    // carry into each divider stage: all lower stages high
    assign psc_carry[0] = 1'b1;
    for (genvar g = 1; g < tec_pkg::PSC_STAGES; g++) begin : g_psc_carry
        assign psc_carry[g] = &psc_div[g-1:0];
    end

    // ripple of toggle stages; stage n toggles when all lower stages are high
    // the divider runs free, so the first tick after setting the run bit may come early
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            psc_div <= '0;
        end else if (clk_en && src_pulse) begin
            psc_div <= psc_div ^ psc_carry;
        end
    end

    // divide-by-1 follows the source pulse itself; others are divider bits
    assign prescaler_input_clock = (prescale_sel == 3'h0) ? src_pulse
        : psc_div[prescale_sel - 3'h1];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_prev <= 1'b0;
        end else if (clk_en) begin
            tick_prev <= prescaler_input_clock;
        end
    end

    // count on high-to-low of the prescaled tick; divide-by-1 counts every source pulse
    assign tick_fall = (prescale_sel == 3'h0) ? src_pulse : (tick_prev && !prescaler_input_clock);

    // ------------------------------------------------------------
    // pulse measurement sequencing
    // ------------------------------------------------------------
    // polarity picks which edge starts and which ends the pulse
    assign start_edge = edge_polarity ? pin_rise : pin_fall;
    assign stop_edge = edge_polarity ? pin_fall : pin_rise;

    // arm on run bit, measure from start edge; counting starts at the next tick, stop edge ends at once
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pstate <= tec_pkg::TEC_IDLE;
        end else if (clk_en) begin
            case (pstate)
                tec_pkg::TEC_IDLE: begin
                    if (count_run && count_mode_sel == tec_pkg::MODE_PULSE) begin
                        pstate <= tec_pkg::TEC_ARMED;
                    end
                end
                tec_pkg::TEC_ARMED: begin
                    if (!count_run || count_mode_sel != tec_pkg::MODE_PULSE) begin
                        pstate <= tec_pkg::TEC_IDLE;
                    end else if (start_edge) begin
                        pstate <= tec_pkg::TEC_MEASURE;
                    end
                end
                tec_pkg::TEC_MEASURE: begin
                    if (!count_run || count_mode_sel != tec_pkg::MODE_PULSE || stop_edge) begin
                        pstate <= tec_pkg::TEC_IDLE;
                    end
                end
                default: begin
                    pstate <= tec_pkg::TEC_IDLE;
                end
            endcase
        end
    end

    assign pulse_end = (pstate == tec_pkg::TEC_MEASURE) && stop_edge && count_run;

    // ------------------------------------------------------------
    // counter step and overflow
    // ------------------------------------------------------------
    // a count read or preload write blocks the step
    assign inhibit = bus_req.rd && bus_req.addr == tec_pkg::COUNT_VALUE_OFS || wr_cnt;

    // step only while running, per mode
    always_comb begin
        count_step = 1'b0;
        case (count_mode_sel)
            tec_pkg::MODE_EVENT: count_step = edge_polarity ? pin_fall : pin_rise;
            tec_pkg::MODE_TIMER: count_step = tick_fall;
            tec_pkg::MODE_PULSE: begin
                count_step = tick_fall && pstate == tec_pkg::TEC_MEASURE && !stop_edge;
            end
            default: count_step = 1'b0;
        endcase
        count_step = count_step && count_run && !inhibit;
    end

    assign ovf = count_step && count_value_reg == tec_pkg::COUNT_FULL;

    // reload preload at overflow; stopped write loads counter at once
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            preload <= tec_pkg::COUNT_VALUE_RST;
            count_value_reg <= tec_pkg::COUNT_VALUE_RST;
        end else if (clk_en) begin
            if (wr_cnt) begin
                preload <= bus_req.wdata;
            end
            if (wr_cnt && !count_run) begin
                count_value_reg <= bus_req.wdata;
            end else if (ovf) begin
                count_value_reg <= preload;
            end else if (count_step) begin
                count_value_reg <= count_value_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // mode control register
    // ------------------------------------------------------------
    // hardware clears run bit at pulse end; software write in same cycle wins
    // outside pulse mode hardware clears only on a stop edge in the cycle after a write quits pulse mode mid-measure
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_mode_control <= tec_pkg::MODE_CONTROL_RST;
        end else if (clk_en) begin
            if (wr_ctl) begin
                timer_mode_control <= bus_req.wdata;
            end else if (pulse_end) begin
                timer_mode_control[tec_pkg::RUN_POS] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read data and event outputs
    // ------------------------------------------------------------
    // read data valid in the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            if (bus_req.rd && bus_req.addr == tec_pkg::COUNT_VALUE_OFS) begin
                rdata <= count_value_reg;
            end else if (bus_req.rd && bus_req.addr == tec_pkg::MODE_CONTROL_OFS) begin
                rdata <= timer_mode_control;
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    // one-cycle request pulse per overflow; wake-up alongside it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overflow_irq <= 1'b0;
            wake_up <= 1'b0;
        end else if (clk_en) begin
            overflow_irq <= ovf;
            wake_up <= ovf;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // pulse end as the control register sees it: no software write competes
    sequence pulse_done_s;
        clk_en && pulse_end && !wr_ctl;
    endsequence

    property run_cleared_p;
        @(posedge sys_clk) disable iff (reset) pulse_done_s |=> !count_run;
    endproperty

    run_clear_a: assert property (run_cleared_p) else $error("run bit not cleared");

    hold_count_a: assert property (@(posedge sys_clk) disable iff (reset)
        (pulse_done_s and !wr_cnt) ##1 (!clk_en || !count_run)
        |-> $stable(count_value_reg)) else $error("count moved after pulse");

    irq_on_ovf_a: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && count_run && count_value_reg == 8'hff && count_step && !wr_cnt
        |=> overflow_irq && wake_up && count_value_reg == $past(preload))
        else $error("overflow missing");

    stopped_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        !count_run && !bus_req.wr |=> $stable(count_value_reg))
        else $error("counter moved while stopped");

    inhibit_read_a: assert property (@(posedge sys_clk) disable iff (reset)
        bus_req.rd && bus_req.addr == 2'h0 |=> $stable(count_value_reg))
        else $error("count moved during read");

    stop_load_a: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && wr_cnt && !count_run |=> count_value_reg == $past(bus_req.wdata))
        else $error("stopped preload not loaded");

    sw_only_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
        count_run && count_mode_sel != 2'h3 && !wr_ctl |=> count_run)
        else $error("run bit cleared by hardware");

    event_step_a: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && count_run && count_mode_sel == 2'h1 && !edge_polarity && pin_rise
        && !inhibit && count_value_reg != 8'hff
        |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("event edge not counted");

    armed_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
        pstate == tec_pkg::TEC_ARMED && count_mode_sel == tec_pkg::MODE_PULSE |-> !count_step)
        else $error("counted before start edge");

    // armed and the starting edge seen while still in pulse mode with the run bit set
    sequence armed_start_s;
        clk_en && pstate == tec_pkg::TEC_ARMED && count_run
        && count_mode_sel == tec_pkg::MODE_PULSE && start_edge;
    endsequence

    start_measure_a: assert property (@(posedge sys_clk) disable iff (reset)
        armed_start_s |=> pstate == tec_pkg::TEC_MEASURE)
        else $error("start edge did not begin measuring");

    pulse_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
        pulse_done_s |=> pstate == tec_pkg::TEC_IDLE)
        else $error("edges not ignored after pulse");

    unused_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
        count_mode_sel == tec_pkg::MODE_UNUSED |-> !count_step)
        else $error("unused mode counted");

    pulse_tick_a: assert property (@(posedge sys_clk) disable iff (reset)
        count_mode_sel == tec_pkg::MODE_PULSE && count_step |-> tick_fall)
        else $error("pulse count off the timer tick");

    timer_step_a: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && count_run && count_mode_sel == tec_pkg::MODE_TIMER && tick_fall && !inhibit
        && count_value_reg != tec_pkg::COUNT_FULL
        |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("timer tick not counted");

endmodule : tec_timer

/* File: verification/tec_pulse_src.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// external pulse source on the event pin
// ------------------------------------------------------------
module tec_pulse_src (
    // clock
    input wire logic sys_clk,
    // pulse request
    input wire logic start,
    input wire logic [7:0] width,
    input wire logic idle_lvl,
    // pin and status
    output logic event_input_pin,
    output logic busy
);
    logic [7:0] left;
    // pin only driven here, block side is input
    // drives the active level for width cycles, idle level otherwise
    always_ff @(posedge sys_clk) begin
        if (start) begin
            left <= width;
            event_input_pin <= ~idle_lvl;
        end else if (left > 8'h01) begin
            left <= left - 8'h01;
        end else begin
            left <= 8'h00;
            event_input_pin <= idle_lvl;
        end
    end
    assign busy = (left != 8'h00);
endmodule : tec_pulse_src

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic sub_clock = 1'b0;
    tec_pkg::tec_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic ev_pin, overflow_irq, wake_up, p_start = 1'b0, p_idle = 1'b0, p_busy;
    logic [7:0] p_width = 8'h00;
    logic [7:0] rv, rv2;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    tec_timer u_tec_timer (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .bus_req(bus_req), .rdata(rdata), .sub_clock(sub_clock),
        .event_input_pin(ev_pin), .overflow_irq(overflow_irq), .wake_up(wake_up));
    tec_pulse_src u_tec_pulse_src (.sys_clk(sys_clk), .start(p_start), .width(p_width),
        .idle_lvl(p_idle), .event_input_pin(ev_pin), .busy(p_busy));
    // clocks: sub clock offset from sys edges to keep its ticks evenly spaced
    always #5 sys_clk = ~sys_clk;
    initial #3 forever #35 sub_clock = ~sub_clock;
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // cycles until the next overflow pulse, which must carry the wake-up too
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1 c++;
        end while (overflow_irq !== 1'b1 && c < 5000);
        check({15'h0000, wake_up}, 16'h0001);
    endtask : wait_irq
    task automatic pulse(input logic [7:0] w);
        @(posedge sys_clk);
        p_width <= w;
        p_start <= 1'b1;
        @(posedge sys_clk);
        p_start <= 1'b0;
    endtask : pulse
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        // reset values, unmapped offsets
        rd(2'h1, rv); check(rv, tec_pkg::MODE_CONTROL_RST);
        rd(2'h0, rv); check(rv, tec_pkg::COUNT_VALUE_RST);
        wr(2'h3, 8'h55);
        rd(2'h3, rv); check(rv, 8'h00);
        rd(2'h1, rv); check(rv, 8'h08);
        // every prescale code, exact overflow spacing
        for (int p = 0; p < 8; p++) begin
            wr(2'h1, 8'h80);
            wr(2'h0, 8'hf0);
            rd(2'h0, rv); check(rv, 8'hf0);
            wr(2'h1, 8'h90 | 8'(p));
            wait_irq(n);
            wait_irq(n); check(16'(n), 16'(16 << p));
        end
        // preload written while running waits for overflow
        wr(2'h1, 8'h90);
        wait_irq(n);
        wr(2'h0, 8'he0);
        wait_irq(n);
        wait_irq(n); check(16'(n), 16'd32);
        rd(2'h1, rv); check(rv, 8'h90);
        // clock enable low for 10 edges stretches one 32-cycle period; counted from 11 in
        wait_irq(n);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
        wait_irq(n); check(16'(n), 16'd31);
        // sub clock source, one tick every 7 cycles
        wr(2'h1, 8'hb0);
        wait_irq(n);
        wait_irq(n); check(16'(n), 16'd224);
        wr(2'h1, 8'h80);
        rd(2'h0, rv);
        repeat (100) @(posedge sys_clk);
        rd(2'h0, rv2); check(rv2, rv);
        // unused mode code never counts, even with the run bit set
        wr(2'h1, 8'h10);
        repeat (20) @(posedge sys_clk);
        rd(2'h0, rv2); check(rv2, rv);
        wr(2'h1, 8'h80);
        // event count on rising edge, then on falling edge
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h50);
        pulse(8'd30);
        repeat (12) @(posedge sys_clk);
        rd(2'h0, rv); check(rv, 8'h01);
        repeat (30) @(posedge sys_clk);
        rd(2'h0, rv); check(rv, 8'h01);
        wr(2'h1, 8'h58);
        pulse(8'd30);
        repeat (12) @(posedge sys_clk);
        rd(2'h0, rv); check(rv, 8'h01);
        repeat (30) @(posedge sys_clk);
        rd(2'h0, rv); check(rv, 8'h02);
        rd(2'h1, rv); check(rv, 8'h58);
        // pulse width, active low pulse then active high pulse
        for (int e = 0; e < 2; e++) begin
            p_idle <= (e == 0);
            wr(2'h1, (e == 0) ? 8'hc0 : 8'hc8);
            wr(2'h0, 8'h00);
            wr(2'h1, (e == 0) ? 8'hd0 : 8'hd8);
            repeat (20) @(posedge sys_clk);
            rd(2'h0, rv); check(rv, 8'h00);
            pulse(8'd40);
            repeat (50) @(posedge sys_clk);
            rd(2'h0, rv);
            // start seen one tick late, stop at once, count one under width
            check({15'h0000, rv >= 8'd39 && rv <= 8'd41}, 16'h0001);
            rd(2'h1, rv2); check(rv2, (e == 0) ? 8'hc0 : 8'hc8);
            pulse(8'd20);
            repeat (30) @(posedge sys_clk);
            rd(2'h0, rv2); check(rv2, rv);
        end
        stop_test();
    end
endmodule : testbench
